// *** hw/pph_pkg.sv ***
`default_nettype none
package pph_pkg;
    // ---------------------------------------------------------------
    // device register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MODE = 8'h08;
    localparam logic [7:0] REG_VOLT = 8'h09;
    localparam logic [7:0] REG_CHG = 8'h10;
    localparam logic [7:0] REG_WARN = 8'h11;
    localparam logic [7:0] REG_CAPLIM = 8'h12;
    localparam logic [7:0] REG_OPTM = 8'h13;
    // ---------------------------------------------------------------
    // field positions and codes
    // ---------------------------------------------------------------
    localparam int MODE_EOD = 0;
    localparam int MODE_ECM = 1;
    localparam int MODE_ACT = 2;
    localparam logic [2:0] MODE_STANDBY = 3'b000;
    localparam logic [2:0] MODE_CONT = 3'b010;
    localparam logic [2:0] MODE_CONT_ACT = 3'b110;
    localparam int HIZ_BIT = 4;
    localparam int WARN_EN_BIT = 4;
    localparam int ST_READY = 0;
    localparam int ST_EW = 1;
    localparam int ST_ALRM = 2;
    localparam int ST_LOWBAT = 3;
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    // charge current field 3'b011 selects 8 mA
    localparam logic [7:0] CHG_RST = 8'h60;
    // output target field 4'h6 selects 3.0 V
    localparam logic [7:0] VOLT_RST = 8'h06;
    localparam logic [7:0] WARN_RST = 8'h10;
    localparam logic [7:0] CAPLIM_RST = 8'h00;
    localparam logic [7:0] OPTM_RST = 8'h03;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_KHZ = 200000;
    localparam int POR_WAIT_MS = 20;
    localparam int POR_WAIT_CYC = POR_WAIT_MS * CLK_KHZ;
    // ---------------------------------------------------------------
    // host csr offsets
    // ---------------------------------------------------------------
    localparam logic [3:0] CSR_CTRL = 4'h0;
    localparam logic [3:0] CSR_CFG0 = 4'h4;
    localparam logic [3:0] CSR_CFG1 = 4'h8;
    localparam logic [3:0] CSR_STAT = 4'hC;
    localparam int CTRL_GO_OD = 0;
    localparam int CTRL_GO_CM = 1;
    localparam int CTRL_DONE = 2;
    localparam int CTRL_RET = 3;
endpackage
`default_nettype wire

// *** hw/pph_link_if.sv ***
`default_nettype none
interface pph_link_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;
    logic ready_pin;
    modport dev (input req, we, addr, wdata, output ack, rdata, ready_pin);
    modport host (output req, we, addr, wdata, input ack, rdata, ready_pin);
endinterface
`default_nettype wire

// *** hw/pph_dev.sv ***
`default_nettype none
module pph_dev
    import pph_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // link
    pph_link_if.dev lk,
    // analog side
    input wire logic cap_full,
    input wire logic early_warn_in,
    input wire logic alarm_in,
    input wire logic low_bat_in,
    output logic charge_en,
    output logic [2:0] charge_current_sel,
    output logic [3:0] vset_sel,
    output logic [3:0] vfix_sel,
    output logic regulator_on,
    output logic regulated_output_hiz,
    output logic always_on_output_from_reg,
    output logic early_warning_flag
);
    typedef enum logic [3:0] {
        DS_STB = 4'b0001,
        DS_CHG = 4'b0010,
        DS_HOLD = 4'b0100,
        DS_ACT = 4'b1000
    } pph_dstate_t;

    typedef struct packed {
        pph_dstate_t st;
        logic ack;
        logic [7:0] rdata;
        logic [7:0] mode;
        logic [7:0] volt;
        logic [7:0] chg;
        logic [7:0] warn;
        logic [7:0] caplim;
        logic [7:0] optm;
        logic ew;
        logic alrm;
        logic rdy_pin;
        logic chg_en;
        logic reg_on;
        logic hiz;
        logic aon_reg;
    } pph_dev_t;

    pph_dev_t q;
    pph_dev_t d;
    logic take;
    logic ready;
    logic stb_wr;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        take = lk.req & ~q.ack;
        stb_wr = take & lk.we & (lk.addr == REG_MODE) &
            (lk.wdata[2:0] == MODE_STANDBY);
        case (q.st)
            DS_STB: begin
                if (q.mode[MODE_EOD] | q.mode[MODE_ECM]) begin
                    d.st = DS_CHG;
                end
            end
            DS_CHG: begin
                if (cap_full) begin
                    d.st = q.mode[MODE_EOD] ? DS_ACT : DS_HOLD;
                end
            end
            DS_HOLD: begin
                if (q.mode[MODE_ACT]) begin
                    d.st = DS_ACT;
                end
            end
            DS_ACT: begin
                if (~q.mode[MODE_ACT] & q.mode[MODE_ECM]) begin
                    d.st = DS_CHG;
                end
            end
            default: begin
                d.st = DS_STB;
            end
        endcase
        if (q.mode[2:0] == MODE_STANDBY) begin
            d.st = DS_STB;
        end
        ready = (d.st == DS_ACT) | (d.st == DS_HOLD);
        // flags: a new event wins over the clearing standby write
        if (stb_wr) begin
            d.ew = 1'b0;
            d.alrm = 1'b0;
        end
        if (early_warn_in & q.warn[WARN_EN_BIT] & ~(q.st == DS_STB)) begin
            d.ew = 1'b1;
        end
        if (alarm_in & (q.st == DS_ACT)) begin
            d.alrm = 1'b1;
        end
        // link slave: answer one cycle after the request
        d.ack = take;
        if (take) begin
            d.rdata = 8'h00;
            if (lk.we) begin
                case (lk.addr)
                    REG_MODE: d.mode = lk.wdata;
                    REG_VOLT: d.volt = lk.wdata;
                    REG_CHG: d.chg = lk.wdata;
                    REG_WARN: d.warn = lk.wdata;
                    REG_CAPLIM: d.caplim = lk.wdata;
                    REG_OPTM: d.optm = lk.wdata;
                    default: d.rdata = 8'h00;
                endcase
            end else if (lk.addr == REG_STATUS) begin
                d.rdata = {4'h0, low_bat_in, d.alrm, d.ew, ready};
            end
        end
        d.rdy_pin = ready & ~d.ew;
        d.chg_en = (d.st == DS_CHG);
        d.reg_on = (d.st == DS_ACT);
        d.aon_reg = (d.st == DS_ACT);
        d.hiz = ~(d.st == DS_ACT) & d.chg[HIZ_BIT];
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q <= '0;
            q.st <= DS_STB;
            q.volt <= VOLT_RST;
            q.chg <= CHG_RST;
            q.warn <= WARN_RST;
            q.caplim <= CAPLIM_RST;
            q.optm <= OPTM_RST;
        end else begin
            q <= d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign lk.ack = q.ack;
    assign lk.rdata = q.rdata;
    assign lk.ready_pin = q.rdy_pin;
    assign charge_en = q.chg_en;
    assign charge_current_sel = q.chg[7:5];
    assign vset_sel = q.volt[3:0];
    assign vfix_sel = q.volt[7:4];
    assign regulator_on = q.reg_on;
    assign regulated_output_hiz = q.hiz;
    assign always_on_output_from_reg = q.aon_reg;
    assign early_warning_flag = q.ew;
endmodule
`default_nettype wire

// *** hw/pph_host.sv ***
// Chosen here: register access over Avalon-MM.
`default_nettype none
module pph_host
    import pph_pkg::*;
#(
    parameter int POR_CYC = POR_WAIT_CYC
)(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // load control
    output logic load_en,
    // link
    pph_link_if.host lk
);
    localparam int CW = $clog2(POR_CYC + 1);

    if (POR_CYC < 1) begin : g_por_check
        $error("POR_CYC must be at least 1");
    end

    typedef enum logic [8:0] {
        HS_POR = 9'b0_0000_0001,
        HS_INIT = 9'b0_0000_0010,
        HS_IDLE = 9'b0_0000_0100,
        HS_VOLT = 9'b0_0000_1000,
        HS_MODE = 9'b0_0001_0000,
        HS_WAIT = 9'b0_0010_0000,
        HS_ARM = 9'b0_0100_0000,
        HS_RUN = 9'b0_1000_0000,
        HS_STOP = 9'b1_0000_0000
    } pph_hstate_t;

    typedef struct packed {
        pph_hstate_t st;
        logic [CW-1:0] cnt;
        logic [1:0] idx;
        logic req;
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] dstat;
        logic go_od;
        logic go_cm;
        logic done;
        logic ret;
        logic cont;
        logic load;
        logic init_done;
        logic ew_stop;
        logic alrm_stop;
        logic wreq;
        logic [31:0] rdata;
        logic [31:0] cfg0;
        logic [11:0] cfg1;
    } pph_host_t;

    pph_host_t q;
    pph_host_t d;
    logic fin;
    logic bad;
    logic [7:0] prof;

    // start one link transaction
    function automatic pph_host_t issue(input pph_host_t s,
        input logic we, input logic [7:0] a, input logic [7:0] w);
        s.req = 1'b1;
        s.we = we;
        s.addr = a;
        s.wdata = w;
        return s;
    endfunction

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        fin = q.req & lk.ack;
        prof = {q.cfg1[11:8], 4'h0};
        bad = fin & ~q.we & (lk.rdata[ST_EW] | lk.rdata[ST_ALRM]);
        if (fin) begin
            d.req = 1'b0;
            if (~q.we) begin
                d.dstat = lk.rdata;
            end
        end
        case (q.st)
            HS_POR: begin
                d.cnt = q.cnt + 1'b1;
                if (q.cnt == CW'(POR_CYC - 1)) begin
                    d.st = HS_INIT;
                end
            end
            HS_INIT: begin
                if (~q.req) begin
                    d = issue(d, 1'b1, REG_CHG + {6'h00, q.idx},
                        q.cfg0[8*q.idx +: 8]);
                end else if (fin) begin
                    d.idx = q.idx + 1'b1;
                    if (q.idx == 2'd3) begin
                        d.st = HS_IDLE;
                        d.init_done = 1'b1;
                    end
                end
            end
            HS_IDLE: begin
                if (q.go_od | q.go_cm) begin
                    d.cont = q.go_cm & ~q.go_od;
                    d.go_od = 1'b0;
                    d.go_cm = 1'b0;
                    d.done = 1'b0;
                    d.ret = 1'b0;
                    d.ew_stop = 1'b0;
                    d.alrm_stop = 1'b0;
                    d.st = HS_VOLT;
                end
            end
            HS_VOLT: begin
                if (~q.req) begin
                    d = issue(d, 1'b1, REG_VOLT, q.cfg1[7:0]);
                end else if (fin) begin
                    d.st = HS_MODE;
                end
            end
            HS_MODE: begin
                if (~q.req) begin
                    d = issue(d, 1'b1, REG_MODE, prof |
                        (q.cont ? 8'h02 : 8'h01));
                end else if (fin) begin
                    d.st = HS_WAIT;
                end
            end
            HS_WAIT: begin
                if (~q.req) begin
                    d = issue(d, 1'b0, REG_STATUS, 8'h00);
                end else if (fin & lk.rdata[ST_READY]) begin
                    d.st = q.cont ? HS_ARM : HS_RUN;
                    d.load = ~q.cont;
                end
            end
            HS_ARM: begin
                if (~q.req) begin
                    d = issue(d, 1'b1, REG_MODE,
                        prof | {5'h00, MODE_CONT_ACT});
                end else if (fin) begin
                    d.st = HS_RUN;
                    d.load = 1'b1;
                end
            end
            HS_RUN: begin
                if (~lk.ready_pin | bad) begin
                    d.load = 1'b0;
                    d.ret = 1'b0;
                    d.ew_stop = q.ew_stop | ~lk.ready_pin |
                        (bad & lk.rdata[ST_EW]);
                    d.alrm_stop = q.alrm_stop | (bad & lk.rdata[ST_ALRM]);
                    if (~q.req | fin) begin
                        d.req = 1'b0;
                        d.st = HS_STOP;
                    end
                end else if (q.done & (~q.req | fin)) begin
                    d.load = 1'b0;
                    d.req = 1'b0;
                    d.st = HS_STOP;
                end else if (~q.req) begin
                    d = issue(d, 1'b0, REG_STATUS, 8'h00);
                end
            end
            HS_STOP: begin
                if (~q.req) begin
                    d = issue(d, 1'b1, REG_MODE, prof | {5'h00,
                        (q.ret & q.cont) ? MODE_CONT : MODE_STANDBY});
                end else if (fin) begin
                    d.st = (q.ret & q.cont & ~q.load) ? HS_WAIT : HS_IDLE;
                    d.done = 1'b0;
                    d.ret = 1'b0;
                end
            end
            default: begin
                d.st = HS_IDLE;
            end
        endcase
        // avalon slave: answer in the cycle after the request
        d.wreq = 1'b1;
        if ((avs_read | avs_write) & q.wreq) begin
            d.wreq = 1'b0;
            case (avs_address)
                CSR_CFG0: d.rdata = q.cfg0;
                CSR_CFG1: d.rdata = {20'h0_0000, q.cfg1};
                CSR_STAT: d.rdata = {18'h0_0000, q.cont, q.alrm_stop,
                    q.ew_stop, q.load, ~(q.st == HS_IDLE), q.init_done,
                    q.dstat};
                default: d.rdata = 32'h0000_0000;
            endcase
        end
        if (avs_write & ~q.wreq) begin
            case (avs_address)
                CSR_CTRL: begin
                    d.go_od = d.go_od | avs_writedata[CTRL_GO_OD];
                    d.go_cm = d.go_cm | avs_writedata[CTRL_GO_CM];
                    d.done = d.done | avs_writedata[CTRL_DONE];
                    d.ret = d.ret | avs_writedata[CTRL_RET];
                end
                CSR_CFG0: d.cfg0 = avs_writedata;
                CSR_CFG1: d.cfg1 = avs_writedata[11:0];
                default: d.wreq = 1'b1;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q <= '0;
            q.st <= HS_POR;
            q.wreq <= 1'b1;
            q.cfg0 <= {OPTM_RST, CAPLIM_RST, WARN_RST, CHG_RST};
            q.cfg1 <= {4'h0, VOLT_RST};
        end else begin
            q <= d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign avs_readdata = q.rdata;
    assign avs_waitrequest = q.wreq;
    assign load_en = q.load;
    assign lk.req = q.req;
    assign lk.we = q.we;
    assign lk.addr = q.addr;
    assign lk.wdata = q.wdata;
endmodule
`default_nettype wire

// *** verification/pph_chk.sv ***
`default_nettype none
module pph_chk
    import pph_pkg::*;
#(
    parameter int POR_CYC = POR_WAIT_CYC
)(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // link
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic [7:0] rdata,
    input wire logic ready_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // ---------------------------------------------------------------
    // helper state
    // ---------------------------------------------------------------
    logic [31:0] por_q;
    logic [2:0] nwr_q;
    logic [7:0] lwa_q;
    logic idle_q, stop_q, rdy_q, wr_a, rd_st;
    assign wr_a = ack && we;
    assign rd_st = ack && !we && addr == REG_STATUS;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            por_q <= '0;
            nwr_q <= '0;
            lwa_q <= '0;
            idle_q <= 1'b1;
            stop_q <= 1'b0;
            rdy_q <= 1'b0;
        end else begin
            if (por_q < POR_CYC) por_q <= por_q + 1;
            if (wr_a && nwr_q < 4) nwr_q <= nwr_q + 3'h1;
            if (wr_a) lwa_q <= addr;
            if (wr_a && addr == REG_MODE) idle_q <= wdata[2:0] == MODE_STANDBY;
            if (wr_a) stop_q <= 1'b0;
            else if (rd_st && (rdata[ST_EW] || rdata[ST_ALRM]))
                stop_q <= 1'b1;
            if (wr_a && addr == REG_MODE) rdy_q <= 1'b0;
            else if (rd_st) rdy_q <= rdata[ST_READY];
        end
    end
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    property p_por_wait;
        req |-> por_q >= POR_CYC - 1;
    endproperty
    a_por_wait: assert property (p_por_wait)
        else $error("link request before start-up wait");
    property p_init_order;
        wr_a && nwr_q < 4 |-> addr == REG_CHG + 8'(nwr_q);
    endproperty
    a_init_order: assert property (p_init_order)
        else $error("init writes out of order");
    property p_ack_next;
        req && !ack |=> ack;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("no answer one cycle after request");
    property p_hold;
        req && !ack |=> req && $stable(we) && $stable(addr) && $stable(wdata);
    endproperty
    a_hold: assert property (p_hold)
        else $error("request changed before answer");
    property p_drop;
        ack |=> !ack && !req;
    endproperty
    a_drop: assert property (p_drop)
        else $error("answer or request held past answer");
    property p_ack_req;
        ack |-> req;
    endproperty
    a_ack_req: assert property (p_ack_req)
        else $error("answer without request");
    property p_stop;
        req && we && stop_q
            |-> addr == REG_MODE && wdata[2:0] == MODE_STANDBY;
    endproperty
    a_stop: assert property (p_stop)
        else $error("warning or alarm not followed by standby write");
    property p_volt_first;
        wr_a && addr == REG_MODE && wdata[1:0] != 2'h0 && idle_q
            |-> lwa_q == REG_VOLT;
    endproperty
    a_volt_first: assert property (p_volt_first)
        else $error("cycle enabled without voltage write");
    property p_act_ready;
        wr_a && addr == REG_MODE && wdata[MODE_ACT] |-> rdy_q;
    endproperty
    a_act_ready: assert property (p_act_ready)
        else $error("active set before ready seen");
    property p_rdy_pin;
        rd_st |-> ready_pin == (rdata[ST_READY] && !rdata[ST_EW]);
    endproperty
    a_rdy_pin: assert property (p_rdy_pin)
        else $error("ready pin disagrees with status");
    c_init: cover property (nwr_q == 3'h4);
    c_stop: cover property (rd_st && rdata[ST_EW]);
    c_act: cover property (wr_a && addr == REG_MODE &&
        wdata[2:0] == MODE_CONT_ACT);
    c_ret: cover property (wr_a && addr == REG_MODE && wdata[2:0] == MODE_CONT);
endmodule
`default_nettype wire

// *** verification/pulse_power_host_sequencer_tb.sv ***
`default_nettype none
module pulse_power_host_sequencer_tb
    import pph_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int POR = 20;
    logic clock = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic cap_full = 1'b0, early_warn_in = 1'b0, alarm_in = 1'b0;
    logic low_bat_in = 1'b0;
    logic [3:0] avs_address = '0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata, q, cfg0;
    logic avs_waitrequest, load_en, charge_en, regulator_on;
    logic regulated_output_hiz, always_on_output_from_reg, early_warning_flag;
    logic [2:0] charge_current_sel, ich;
    logic [3:0] vset_sel, vfix_sel, prof;
    logic [7:0] vb;
    logic [15:0] wr_q[$];
    int mismatches = 0, tests_run = 0, seed = 22778;
    always #2.5 clock = ~clock;
    // ---------------------------------------------------------------
    // both ends
    // ---------------------------------------------------------------
    pph_link_if lk_if ();
    pph_dev pph_dev_inst (.clock(clock), .sys_rst(sys_rst), .lk(lk_if),
        .cap_full(cap_full), .early_warn_in(early_warn_in),
        .alarm_in(alarm_in), .low_bat_in(low_bat_in), .charge_en(charge_en),
        .charge_current_sel(charge_current_sel), .vset_sel(vset_sel),
        .vfix_sel(vfix_sel), .regulator_on(regulator_on),
        .regulated_output_hiz(regulated_output_hiz),
        .always_on_output_from_reg(always_on_output_from_reg),
        .early_warning_flag(early_warning_flag));
    pph_host #(.POR_CYC(POR)) pph_host_inst (.clock(clock), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .load_en(load_en), .lk(lk_if));
    pph_chk #(.POR_CYC(POR)) pph_chk_inst (.clock(clock), .sys_rst(sys_rst),
        .req(lk_if.req), .we(lk_if.we), .addr(lk_if.addr),
        .wdata(lk_if.wdata), .ack(lk_if.ack), .rdata(lk_if.rdata),
        .ready_pin(lk_if.ready_pin));
    // link write log for the model
    always @(posedge clock)
        if (lk_if.req && lk_if.ack && lk_if.we)
            wr_q.push_back({lk_if.addr, lk_if.wdata});
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic av(input logic wr, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] rd);
        int n;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) begin
            mismatches++;
            summarize();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: return charge_en;
            1: return load_en;
            default: return regulator_on;
        endcase
    endfunction
    task automatic wait_for(input int k, input logic v);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (sig(k) !== v && n < 4000);
        if (n >= 4000) begin
            mismatches++;
            summarize();
        end
    endtask
    task automatic stat_bit(input int b, input logic e);
        av(1'b0, CSR_STAT, '0, q);
        check(q[b], e);
    endtask
    task automatic run_cycle(input logic cont);
        logic [3:0] mc;
        mc = cont ? 4'h2 : 4'h1;
        vb = 8'($random(seed));
        prof = 4'($random(seed));
        wr_q.delete();
        av(1'b1, CSR_CFG1, {20'h0_0000, prof, vb}, q);
        av(1'b1, CSR_CTRL, {30'h0000_0000, cont, !cont}, q);
        wait_for(0, 1'b1);
        check(charge_current_sel, ich);
        @(posedge clock);
        cap_full <= 1'b1;
        wait_for(1, 1'b1);
        check(vset_sel, vb[3:0]);
        check(vfix_sel, vb[7:4]);
        check(regulator_on, 1'b1);
        check(always_on_output_from_reg, 1'b1);
        check(regulated_output_hiz, 1'b0);
        check(lk_if.ready_pin, 1'b1);
        check(wr_q[0], {REG_VOLT, vb});
        check(wr_q[1], {REG_MODE, prof, mc});
        if (cont)
            check(wr_q[2], {REG_MODE, prof, 4'h6});
    endtask
    task automatic end_cycle(input string name);
        wait_for(2, 1'b0);
        repeat (3) @(negedge clock);
        check(load_en, 1'b0);
        check(always_on_output_from_reg, 1'b0);
        check(regulated_output_hiz, 1'b1);
        check(early_warning_flag, 1'b0);
        @(posedge clock);
        cap_full <= 1'b0;
        early_warn_in <= 1'b0;
        alarm_in <= 1'b0;
        low_bat_in <= 1'b0;
        $display("test %s done", name);
    endtask
    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial begin
        int n;
        repeat (20) @(posedge clock);
        #1;
        check(charge_current_sel, 3'b011);
        check(vset_sel, 4'h6);
        check(always_on_output_from_reg, 1'b0);
        check(lk_if.req, 1'b0);
        @(posedge clock);
        sys_rst <= 1'b0;
        ich = 3'($random(seed));
        cfg0 = {OPTM_RST, CAPLIM_RST, WARN_RST, ich, 1'b1, 4'h0};
        av(1'b1, CSR_CFG0, cfg0, q);
        av(1'b1, 4'h2, $random(seed), q);
        av(1'b0, 4'h2, '0, q);
        check(q, 32'h0000_0000);
        av(1'b0, CSR_CFG1, '0, q);
        check(q, 32'h0000_0006);
        n = 0;
        do begin
            av(1'b0, CSR_STAT, '0, q);
            n++;
        end while (q[8] !== 1'b1 && n < 200);
        if (n >= 200) begin
            mismatches++;
            summarize();
        end
        check(q[9:8], 2'b01);
        check(32'(wr_q.size()), 32'h0000_0004);
        for (int i = 0; i < 4; i++)
            check(wr_q[i], {REG_CHG + 8'(i), cfg0[8*i +: 8]});
        check(charge_current_sel, ich);
        check(regulated_output_hiz, 1'b1);
        $display("test init done");
        run_cycle(1'b0);
        @(posedge clock);
        low_bat_in <= 1'b1;
        repeat (40) @(negedge clock);
        check(load_en, 1'b1);
        stat_bit(3, 1'b1);
        av(1'b1, CSR_CTRL, 32'h0000_0004, q);
        end_cycle("on-demand");
        run_cycle(1'b0);
        @(posedge clock);
        early_warn_in <= 1'b1;
        wait_for(1, 1'b0);
        check(early_warning_flag, 1'b1);
        @(posedge clock);
        early_warn_in <= 1'b0;
        stat_bit(11, 1'b1);
        end_cycle("early warning");
        run_cycle(1'b1);
        @(posedge clock);
        alarm_in <= 1'b1;
        wait_for(1, 1'b0);
        @(posedge clock);
        alarm_in <= 1'b0;
        stat_bit(12, 1'b1);
        end_cycle("alarm");
        run_cycle(1'b1);
        av(1'b1, CSR_CTRL, 32'h0000_000C, q);
        wait_for(2, 1'b0);
        wait_for(1, 1'b1);
        check(regulator_on, 1'b1);
        stat_bit(13, 1'b1);
        av(1'b1, CSR_CTRL, 32'h0000_0004, q);
        end_cycle("continuous return");
        summarize();
    end
endmodule
`default_nettype wire
